//--- verilog/keypad_wake_pkg.sv
package keypad_wake_pkg;
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam int NUM_KEYS = 8;
    localparam int NUM_EVENTS = 2;
    // register offsets
    localparam logic [ADDR_W-1:0] OFF_STATUS_CONTROL = 2'h0;
    localparam logic [ADDR_W-1:0] OFF_PIN_ENABLE = 2'h1;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 2'h2;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 2'h3;
    // status/control field positions
    localparam int POS_MODE = 0;
    localparam int POS_IRQ_EN = 1;
    localparam int POS_ACK = 2;
    localparam int POS_FLAG = 3;
    localparam int POS_POL_LO = 4;
    localparam int POS_POL_HI = 7;
    // interrupt status bit positions
    localparam int EV_FLAG_SET = 0;
    localparam int EV_STOP_WAKE = 1;
    // reset values
    localparam logic [7:0] RST_PIN_ENABLE = 8'h00;
    localparam logic [3:0] RST_POLARITY = 4'h0;
    localparam logic RST_MODE = 1'b0;
    localparam logic RST_IRQ_EN = 1'b0;
    localparam logic RST_FLAG = 1'b0;
    localparam logic [NUM_EVENTS-1:0] RST_IRQ_STATUS = 2'h0;
    localparam logic [NUM_EVENTS-1:0] RST_IRQ_MASK = 2'h0;
    // lower half polarity is fixed falling/low
    localparam logic [3:0] FIXED_LOW_POLARITY = 4'h0;
endpackage

//--- verilog/key_pin_sampler.sv
`timescale 1ns/10ps
`default_nettype none
// two-stage synchroniser plus one history stage per pin
module key_pin_sampler #(
    parameter int WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_pins,
    output logic [WIDTH-1:0] o_now,
    output logic [WIDTH-1:0] o_prev
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] now;
    logic [WIDTH-1:0] prev;

    // meta is read only by now; prev holds the previous bus cycle sample
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            meta <= '0;
            now <= '0;
            prev <= '0;
        end else begin
            meta <= i_pins;
            now <= meta;
            prev <= now;
        end
    end

    assign o_now = now;
    assign o_prev = prev;
endmodule
`default_nettype wire

//--- verilog/keypad_wake_unit.sv
`timescale 1ns/10ps
`default_nettype none
module keypad_wake_unit #(
    parameter int NUM_PINS = 8
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [keypad_wake_pkg::ADDR_W-1:0] i_addr,
    input wire logic [keypad_wake_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [keypad_wake_pkg::DATA_W-1:0] o_rdata,
    input wire logic [NUM_PINS-1:0] i_pin_in,
    input wire logic [NUM_PINS-1:0] i_port_out,
    input wire logic [NUM_PINS-1:0] i_port_dir,
    input wire logic [NUM_PINS-1:0] i_port_pull,
    input wire logic i_stop_mode,
    output logic [NUM_PINS-1:0] o_pin_out,
    output logic [NUM_PINS-1:0] o_pin_oe,
    output logic [NUM_PINS-1:0] o_pullup_en,
    output logic [NUM_PINS-1:0] o_pulldown_en,
    output logic o_key_irq,
    output logic o_irq,
    output logic o_wake
);
    import keypad_wake_pkg::*;

    // software-visible state
    logic [NUM_PINS-1:0] key_pin_enable;
    logic [3:0] trigger_polarity_select;
    logic detect_mode_select;
    logic key_irq_enable;
    logic key_event_flag;
    logic [NUM_EVENTS-1:0] irq_status;
    logic [NUM_EVENTS-1:0] irq_mask;
    logic [DATA_W-1:0] rdata;
    logic stop_seen;
    logic stop_level_seen;

    // sampled pins
    logic [NUM_PINS-1:0] pin_now;
    logic [NUM_PINS-1:0] pin_prev;

    // decode wires
    logic wr_status_control;
    logic wr_pin_enable;
    logic wr_irq_mask;
    logic rd_irq_status;
    logic key_event_acknowledge;
    logic [NUM_PINS-1:0] polarity_full;
    logic [NUM_PINS-1:0] asserted_now;
    logic [NUM_PINS-1:0] asserted_prev;
    logic [NUM_PINS-1:0] edge_hit;
    logic [NUM_PINS-1:0] raw_asserted;
    logic [NUM_PINS-1:0] input_side;
    logic [NUM_PINS-1:0] pull_on;
    logic [NUM_PINS-1:0] use_pulldown;
    logic any_edge;
    logic any_level;
    logic flag_set;
    logic async_level_wake;
    logic stop_exit_wake;
    logic [NUM_EVENTS-1:0] events;
    logic [DATA_W-1:0] status_control_view;
    logic [DATA_W-1:0] next_rdata;
    logic next_flag;
    logic [NUM_EVENTS-1:0] next_irq_status;

    // pin index n maps straight onto port bit n
    key_pin_sampler #(
        .WIDTH(NUM_PINS)
    ) key_pin_sampler_inst (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_pins(i_pin_in),
        .o_now(pin_now),
        .o_prev(pin_prev)
    );

    // register strobes
    assign wr_status_control = i_write && (i_addr == OFF_STATUS_CONTROL);
    assign wr_pin_enable = i_write && (i_addr == OFF_PIN_ENABLE);
    assign wr_irq_mask = i_write && (i_addr == OFF_IRQ_MASK);
    assign rd_irq_status = i_read && (i_addr == OFF_IRQ_STATUS);
    assign key_event_acknowledge = wr_status_control && i_wdata[POS_ACK];

    // lower four pins have fixed falling/low polarity
    assign polarity_full = {trigger_polarity_select, FIXED_LOW_POLARITY};

    // a pin is asserted when its level equals its polarity bit
    assign asserted_now = key_pin_enable & ~(pin_now ^ polarity_full);
    assign asserted_prev = key_pin_enable & ~(pin_prev ^ polarity_full);

    // edge: deasserted one bus cycle, asserted the next
    assign edge_hit = asserted_now & ~asserted_prev;
    assign any_edge = |edge_hit;
    assign any_level = |asserted_now;

    // level mode keeps setting the flag while any pin is asserted
    assign flag_set = any_edge || (detect_mode_select && any_level);
    assign next_flag = flag_set || (key_event_flag && !key_event_acknowledge);

    // interrupt request gated by enable; flag itself still polls
    assign o_key_irq = key_event_flag && key_irq_enable;

    // stop mode: unclocked level path straight from the pads
    assign raw_asserted = key_pin_enable & ~(i_pin_in ^ polarity_full);
    assign async_level_wake = i_stop_mode && (|raw_asserted);

    // wake from wait through the request, from stop through the level
    assign o_wake = o_key_irq || async_level_wake;

    // stop exit with a key still asserted is logged as a wake event
    assign stop_exit_wake = stop_seen && !i_stop_mode && stop_level_seen;

    // sticky interrupt events; set wins over the read clear
    assign events[EV_FLAG_SET] = flag_set && !key_event_flag;
    assign events[EV_STOP_WAKE] = stop_exit_wake;
    assign next_irq_status = events | (rd_irq_status ? '0 : irq_status);
    assign o_irq = |(irq_status & irq_mask);

    // port side: key pins become inputs, others follow the port
    assign input_side = ~i_port_dir | key_pin_enable;
    assign o_pin_oe = ~input_side;
    assign o_pin_out = i_port_out;

    // pull enable becomes pulldown on enabled key pins of the upper half with rising polarity
    assign pull_on = i_port_pull & input_side;
    assign use_pulldown = key_pin_enable & polarity_full;
    assign o_pulldown_en = pull_on & use_pulldown;
    assign o_pullup_en = pull_on & ~use_pulldown;

    // status/control read view; acknowledge bit reads as zero
    assign status_control_view = {trigger_polarity_select, key_event_flag,
        1'b0, key_irq_enable, detect_mode_select};

    // read data mux, unmapped reads give zero
    always_comb begin
        next_rdata = '0;
        case (i_addr)
            OFF_STATUS_CONTROL: begin
                next_rdata = status_control_view;
            end
            OFF_PIN_ENABLE: begin
                next_rdata = key_pin_enable;
            end
            OFF_IRQ_STATUS: begin
                next_rdata = {{(DATA_W-NUM_EVENTS){1'b0}}, irq_status};
            end
            OFF_IRQ_MASK: begin
                next_rdata = {{(DATA_W-NUM_EVENTS){1'b0}}, irq_mask};
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    // status/control fields
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            trigger_polarity_select <= RST_POLARITY;
            key_irq_enable <= RST_IRQ_EN;
            detect_mode_select <= RST_MODE;
        end else if (wr_status_control) begin
            trigger_polarity_select <= i_wdata[POS_POL_HI:POS_POL_LO];
            key_irq_enable <= i_wdata[POS_IRQ_EN];
            detect_mode_select <= i_wdata[POS_MODE];
        end
    end

    // pin enable register
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            key_pin_enable <= RST_PIN_ENABLE;
        end else if (wr_pin_enable) begin
            key_pin_enable <= i_wdata[NUM_PINS-1:0];
        end
    end

    // common key flag
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            key_event_flag <= RST_FLAG;
        end else begin
            key_event_flag <= next_flag;
        end
    end

    // interrupt status and mask
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            irq_status <= RST_IRQ_STATUS;
            irq_mask <= RST_IRQ_MASK;
        end else begin
            irq_status <= next_irq_status;
            if (wr_irq_mask) begin
                irq_mask <= i_wdata[NUM_EVENTS-1:0];
            end
        end
    end

    // remember stop mode and whether a key level was present in it
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            stop_seen <= 1'b0;
            stop_level_seen <= 1'b0;
        end else begin
            stop_seen <= i_stop_mode;
            stop_level_seen <= i_stop_mode && any_level;
        end
    end

    // read data valid the cycle after the read strobe
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            rdata <= '0;
        end else if (i_read) begin
            rdata <= next_rdata;
        end else begin
            rdata <= '0;
        end
    end

    assign o_rdata = rdata;

    // checks

    // a falling edge on pin 0 seen by the sampler sets the flag one cycle later
    property p_low_pin_edge;
        @(posedge i_clk) disable iff (!i_reset_n)
        (key_pin_enable[0] && pin_prev[0] && !pin_now[0])
            |=> key_event_flag;
    endproperty
    a_low_pin_edge:
    assert property (p_low_pin_edge)
    else $error("falling edge on pin 0 did not set the flag");

    // rising edge on an upper pin with high polarity sets the flag
    property p_upper_rising;
        @(posedge i_clk) disable iff (!i_reset_n)
        (key_pin_enable[7] && trigger_polarity_select[3]
            && !pin_prev[7] && pin_now[7]) |=> key_event_flag;
    endproperty
    a_upper_rising:
    assert property (p_upper_rising)
    else $error("rising edge on pin 7 did not set the flag");

    // with no pin enabled the flag never sets
    property p_disabled_quiet;
        @(posedge i_clk) disable iff (!i_reset_n)
        (key_pin_enable == '0 && !key_event_flag) |=> !key_event_flag;
    endproperty
    a_disabled_quiet:
    assert property (p_disabled_quiet)
    else $error("flag set with no pin enabled");

    // enabled pins never drive
    property p_forced_input;
        @(posedge i_clk) disable iff (!i_reset_n)
        (o_pin_oe & key_pin_enable) == '0;
    endproperty
    a_forced_input:
    assert property (p_forced_input)
    else $error("enabled key pin has its driver on");

    // pullup and pulldown never together, pulldown only on keyed pins
    property p_pull_choice;
        @(posedge i_clk) disable iff (!i_reset_n)
        ((o_pullup_en & o_pulldown_en) == '0)
            && ((o_pulldown_en & ~key_pin_enable) == '0);
    endproperty
    a_pull_choice:
    assert property (p_pull_choice)
    else $error("pull device choice is wrong");

    // acknowledge in edge mode with no new event clears the flag
    property p_ack_clears;
        @(posedge i_clk) disable iff (!i_reset_n)
        (key_event_acknowledge && !detect_mode_select && !any_edge)
            |=> !key_event_flag;
    endproperty
    a_ack_clears:
    assert property (p_ack_clears)
    else $error("acknowledge did not clear the flag");

    // level mode holds the flag while a pin stays asserted
    property p_level_holds;
        @(posedge i_clk) disable iff (!i_reset_n)
        (detect_mode_select && any_level) |=> key_event_flag [*1];
    endproperty
    a_level_holds:
    assert property (p_level_holds)
    else $error("flag cleared while a key level is asserted");

    // a new event raises the request when enabled, never when disabled
    property p_irq_gate;
        @(posedge i_clk) disable iff (!i_reset_n)
        ((flag_set && key_irq_enable && !wr_status_control) |=> o_key_irq)
            and (!key_irq_enable |-> !o_key_irq);
    endproperty
    a_irq_gate:
    assert property (p_irq_gate)
    else $error("key request does not match flag and enable");

    // acknowledge bit reads back zero
    property p_ack_reads_zero;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_read && i_addr == OFF_STATUS_CONTROL) |=> !o_rdata[POS_ACK];
    endproperty
    a_ack_reads_zero:
    assert property (p_ack_reads_zero)
    else $error("acknowledge bit read back as one");

    // stop-mode low level on pin 0 reaches the wake output at once
    property p_stop_wake;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_stop_mode && key_pin_enable[0] && !i_pin_in[0]) |-> o_wake;
    endproperty
    a_stop_wake:
    assert property (p_stop_wake)
    else $error("stop-mode key level did not request wake");

    // a read of interrupt status clears the bits not set again
    property p_status_clear;
        @(posedge i_clk) disable iff (!i_reset_n)
        (rd_irq_status && events == '0) |=> irq_status == '0;
    endproperty
    a_status_clear:
    assert property (p_status_clear)
    else $error("interrupt status not cleared by read");

    // lower pins never get a pulldown, their polarity is fixed
    property p_lower_pullup;
        @(posedge i_clk) disable iff (!i_reset_n)
        o_pulldown_en[3:0] == 4'h0;
    endproperty
    a_lower_pullup:
    assert property (p_lower_pullup)
    else $error("pulldown enabled on a lower key pin");

    // leaving stop with pin 0 held low logs a stop wake event
    property p_stop_exit;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_stop_mode && key_pin_enable[0] && !pin_now[0]) ##1 !i_stop_mode
            |=> irq_status[EV_STOP_WAKE];
    endproperty
    a_stop_exit:
    assert property (p_stop_exit)
    else $error("stop exit with key level not logged");
endmodule
`default_nettype wire

//--- verification/key_switch_model.sv
`timescale 1ns/10ps
`default_nettype none
// switches to ground, or to supply on pins whose pulldown is on
module key_switch_model (
    input wire logic i_clk,
    input wire logic [7:0] i_press,
    input wire logic [7:0] i_pullup_en,
    input wire logic [7:0] i_pulldown_en,
    output logic [7:0] o_pins
);
    logic [7:0] churn = 8'h5A;

    // an open line with no pull wanders every cycle
    always @(posedge i_clk) begin
        churn <= ~churn;
    end

    // pressed pins sit asserted, released pins rest at the pull level
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            if (i_press[n])
                o_pins[n] = i_pulldown_en[n];
            else if (i_pulldown_en[n])
                o_pins[n] = 1'b0;
            else if (i_pullup_en[n])
                o_pins[n] = 1'b1;
            else
                o_pins[n] = churn[n];
        end
    end
endmodule
`default_nettype wire

//--- verification/tb_keypad_wake_unit.sv
`timescale 1ns/10ps
`default_nettype none
module tb_keypad_wake_unit;
    import keypad_wake_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset_n, i_write, i_read, i_stop_mode;
    logic [1:0] i_addr;
    logic [7:0] i_wdata, i_port_out, i_port_dir, i_port_pull, press, en;
    logic [7:0] dummy;
    wire logic [7:0] o_rdata, o_pin_out, o_pin_oe, o_pullup_en;
    wire logic [7:0] o_pulldown_en, model_pins, pin_level;
    wire logic o_key_irq, o_irq, o_wake;
    int seed = 32'h5901;
    int n_mismatch = 0;
    int samples_checked = 0;

    always #12.5 i_clk = ~i_clk;

    // pad level: the port driver wins where enabled, else the switches
    assign pin_level = (o_pin_oe & o_pin_out) | (~o_pin_oe & model_pins);

    keypad_wake_unit keypad_wake_unit_inst (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
        .o_rdata(o_rdata), .i_pin_in(pin_level), .i_port_out(i_port_out),
        .i_port_dir(i_port_dir), .i_port_pull(i_port_pull),
        .i_stop_mode(i_stop_mode), .o_pin_out(o_pin_out),
        .o_pin_oe(o_pin_oe), .o_pullup_en(o_pullup_en),
        .o_pulldown_en(o_pulldown_en), .o_key_irq(o_key_irq),
        .o_irq(o_irq), .o_wake(o_wake)
    );

    key_switch_model key_switch_model_inst (
        .i_clk(i_clk), .i_press(press), .i_pullup_en(o_pullup_en),
        .i_pulldown_en(o_pulldown_en), .o_pins(model_pins)
    );

    // expected status/control read value
    function automatic logic [7:0] sc_val(logic [3:0] pol, logic flag,
                                          logic ie, logic mode);
        return {pol, flag, 1'b0, ie, mode};
    endfunction

    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(logic [1:0] a, logic [7:0] d);
        @(posedge i_clk);
        i_write <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_write <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task automatic rd(logic [1:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_read <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_read <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic rd_chk(string what, logic [1:0] a, logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check(what, d, exp);
    endtask

    task automatic idle(int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic set_press(logic [7:0] p);
        @(posedge i_clk);
        press <= p;
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // watchdog, far beyond the 160 or so cycles the tests need
    initial begin
        #(25 * 4000);
        n_mismatch++;
        conclude();
    end

    initial begin
        i_reset_n = 1'b0;
        {i_write, i_read, i_stop_mode, i_addr, i_wdata} = '0;
        {i_port_out, i_port_dir, press} = '0;
        i_port_pull = 8'hFF;
        idle(4);
        i_reset_n <= 1'b1;
        for (int a = 0; a < 4; a++) rd_chk("reset reg", a[1:0], 8'h00);
        check("reset oe", o_pin_oe, i_port_dir);
        $display("test reset done");
        // random pin enables with random port settings
        for (int i = 0; i < 6; i++) begin
            en = $random(seed);
            @(posedge i_clk);
            i_port_dir <= $random(seed);
            i_port_out <= $random(seed);
            wr(OFF_PIN_ENABLE, en);
            rd_chk("pin enable", OFF_PIN_ENABLE, en);
            check("pin oe", o_pin_oe, i_port_dir & ~en);
            check("pin out", o_pin_out, i_port_out);
        end
        i_port_dir <= 8'h00;
        wr(OFF_PIN_ENABLE, 8'h01);
        wr(OFF_STATUS_CONTROL, 8'h06);
        $display("test pin enable done");
        // edge mode on a lower pin: latency, then ack while still held
        set_press(8'h01);
        idle(2);
        #1 check("irq early", o_key_irq, 1'b0);
        @(posedge i_clk);
        #1 check("irq on edge", o_key_irq, 1'b1);
        check("wait wake", o_wake, 1'b1);
        rd_chk("flag set", OFF_STATUS_CONTROL, sc_val(0, 1, 1, 0));
        wr(OFF_STATUS_CONTROL, 8'h06);
        rd_chk("edge ack", OFF_STATUS_CONTROL, sc_val(0, 0, 1, 0));
        check("irq after ack", o_key_irq, 1'b0);
        $display("test edge mode done");
        // level mode: ack refused while the pin stays asserted
        set_press(8'h00);
        idle(4);
        wr(OFF_STATUS_CONTROL, 8'h05);
        set_press(8'h01);
        idle(5);
        rd_chk("level flag", OFF_STATUS_CONTROL, sc_val(0, 1, 0, 1));
        check("polling only", o_key_irq, 1'b0);
        wr(OFF_STATUS_CONTROL, 8'h05);
        rd_chk("held ack", OFF_STATUS_CONTROL, sc_val(0, 1, 0, 1));
        set_press(8'h00);
        idle(4);
        wr(OFF_STATUS_CONTROL, 8'h05);
        rd_chk("free ack", OFF_STATUS_CONTROL, sc_val(0, 0, 0, 1));
        $display("test level mode done");
        // upper pin with rising polarity, and a disabled pin ignored
        wr(OFF_STATUS_CONTROL, 8'h14);
        wr(OFF_PIN_ENABLE, 8'h10);
        idle(4);
        check("pulldown", o_pulldown_en, 8'h10);
        check("pullup", o_pullup_en, 8'hEF);
        set_press(8'h10);
        idle(5);
        rd_chk("rising flag", OFF_STATUS_CONTROL, sc_val(1, 1, 0, 0));
        set_press(8'h00);
        wr(OFF_STATUS_CONTROL, 8'h14);
        set_press(8'h20);
        idle(5);
        rd_chk("disabled pin", OFF_STATUS_CONTROL, sc_val(1, 0, 0, 0));
        $display("test polarity done");
        // event status, mask and read-to-clear
        set_press(8'h00);
        wr(OFF_STATUS_CONTROL, 8'h04);
        wr(OFF_PIN_ENABLE, 8'h01);
        wr(OFF_IRQ_MASK, 8'h01);
        rd(OFF_IRQ_STATUS, dummy);
        set_press(8'h01);
        idle(5);
        check("irq raised", o_irq, 1'b1);
        rd_chk("irq status", OFF_IRQ_STATUS, 8'h01);
        check("irq cleared", o_irq, 1'b0);
        wr(OFF_IRQ_MASK, 8'h00);
        wr(OFF_STATUS_CONTROL, 8'h04);
        set_press(8'h00);
        idle(3);
        set_press(8'h01);
        idle(5);
        check("irq masked", o_irq, 1'b0);
        wr(OFF_IRQ_MASK, 8'h01);
        #1 check("irq unmasked", o_irq, 1'b1);
        rd(OFF_IRQ_STATUS, dummy);
        $display("test interrupt done");
        // stop mode: pad level wakes at once, without the clocked path
        set_press(8'h00);
        wr(OFF_STATUS_CONTROL, 8'h04);
        idle(3);
        i_stop_mode <= 1'b1;
        @(posedge i_clk);
        #1 check("no wake", o_wake, 1'b0);
        set_press(8'h01);
        #1 check("stop wake", o_wake, 1'b1);
        idle(4);
        i_stop_mode <= 1'b0;
        idle(2);
        rd_chk("stop exit", OFF_IRQ_STATUS, 8'h03);
        $display("test stop wake done");
        conclude();
    end
endmodule
`default_nettype wire
